// ---- src/tuning_pkg.sv ----
// Shared constants for the high-speed tuning register bank
package tuning_pkg;
    // Register offsets as seen through the serial target port
    localparam logic [7:0] EUSB_TX_OFS = 8'h05;  // eUSB2-side transmit tuning
    localparam logic [7:0] USB_RX_OFS  = 8'h06;  // usb2_receive_tuning
    localparam logic [7:0] USB_TX_OFS  = 8'h07;  // usb2_transmit_tuning

    // Field positions (least significant bit of each field)
    localparam int SQ_LSB  = 4;  // Squelch threshold, bits 6:4
    localparam int EQ_LSB  = 0;  // Receive equalization, bits 2:0
    localparam int DUR_LSB = 4;  // De-emphasis duration, bits 5:4
    localparam int LVL_LSB = 0;  // De-emphasis level, bits 2:0
    localparam int ESW_LSB = 4;  // eUSB2 output swing, bits 5:4
    localparam int EDE_LSB = 0;  // eUSB2 de-emphasis level, bits 1:0

    // Values after reset
    localparam logic [2:0] SQ_RST  = 3'h4;
    localparam logic [2:0] EQ_RST  = 3'h0;
    localparam logic [1:0] DUR_RST = 2'h2;
    localparam logic [2:0] LVL_RST = 3'h2;
    localparam logic [1:0] ESW_RST = 2'h1;
    localparam logic [1:0] EDE_RST = 2'h0;

    // De-emphasis level code that is never accepted
    localparam logic [2:0] LVL_RESERVED = 3'h7;

    // Serial target address; value is arbitrary
    localparam logic [6:0] TARGET_ADDR = 7'h2a;
endpackage

// ---- src/reg_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Write strobe, pointer and data between the serial front end and the bank
interface reg_if;
    logic       wr_stb;  // One-cycle write pulse
    logic [7:0] addr;    // Register pointer
    logic [7:0] wdata;   // Byte to write
    logic [7:0] rdata;   // Byte read at the pointer
    modport ctrl (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- src/tuning_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Holds the tuning fields and answers reads at the pointer
module tuning_regs (
    input  wire logic       clk_in,     // Core clock
    input  wire logic       rst_n_in,   // Synchronous reset, active low
    reg_if.regs             bus,        // Write and read access
    output logic [2:0]      sq_out,     // Squelch threshold code
    output logic [2:0]      eq_out,     // Receive equalization code
    output logic [1:0]      dur_out,    // De-emphasis duration code
    output logic [2:0]      lvl_out,    // De-emphasis level code
    output logic [1:0]      esw_out,    // eUSB2 swing code
    output logic [1:0]      ede_out     // eUSB2 de-emphasis code
);
    // Field storage
    logic [2:0] sq_q;
    logic [2:0] eq_q;
    logic [1:0] dur_q;
    logic [2:0] lvl_q;
    logic [1:0] esw_q;
    logic [1:0] ede_q;

    // Address decode of the write strobe
    wire logic wr_rx  = bus.wr_stb && (bus.addr == tuning_pkg::USB_RX_OFS);
    wire logic wr_tx  = bus.wr_stb && (bus.addr == tuning_pkg::USB_TX_OFS);
    wire logic wr_etx = bus.wr_stb && (bus.addr == tuning_pkg::EUSB_TX_OFS);
    // Level code check before it is accepted
    wire logic lvl_ok = bus.wdata[tuning_pkg::LVL_LSB +: 3] != tuning_pkg::LVL_RESERVED;

    // Receive tuning register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sq_q <= tuning_pkg::SQ_RST;
            eq_q <= tuning_pkg::EQ_RST;
        end else if (wr_rx) begin
            sq_q <= bus.wdata[tuning_pkg::SQ_LSB +: 3];
            eq_q <= bus.wdata[tuning_pkg::EQ_LSB +: 3];
        end
    end

    // USB2 transmit tuning register; a reserved level code leaves the level alone
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            dur_q <= tuning_pkg::DUR_RST;
            lvl_q <= tuning_pkg::LVL_RST;
        end else if (wr_tx) begin
            dur_q <= bus.wdata[tuning_pkg::DUR_LSB +: 2];
            if (lvl_ok) begin
                lvl_q <= bus.wdata[tuning_pkg::LVL_LSB +: 3];
            end
        end
    end

    // eUSB2 transmit tuning register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            esw_q <= tuning_pkg::ESW_RST;
            ede_q <= tuning_pkg::EDE_RST;
        end else if (wr_etx) begin
            esw_q <= bus.wdata[tuning_pkg::ESW_LSB +: 2];
            ede_q <= bus.wdata[tuning_pkg::EDE_LSB +: 2];
        end
    end

    // Read selection; unused bit slots read as zero, unmapped offsets read zero
    assign bus.rdata = (bus.addr == tuning_pkg::USB_RX_OFS)  ? {1'b0, sq_q, 1'b0, eq_q} :
                       (bus.addr == tuning_pkg::USB_TX_OFS)  ? {2'b00, dur_q, 1'b0, lvl_q} :
                       (bus.addr == tuning_pkg::EUSB_TX_OFS) ? {2'b00, esw_q, 2'b00, ede_q} :
                       8'h00;

    assign sq_out  = sq_q;
    assign eq_out  = eq_q;
    assign dur_out = dur_q;
    assign lvl_out = lvl_q;
    assign esw_out = esw_q;
    assign ede_out = ede_q;

    // Fields other than the eUSB2 swing take their defaults when reset is released
    reset_vals_a: assert property (@(posedge clk_in) $rose(rst_n_in) |->
        sq_q == 3'h4 && eq_q == 3'h0 && dur_q == 2'h2 && lvl_q == 3'h2 && ede_q == 2'h0)
        else $error("reset values wrong");
    // Squelch field follows a write to the receive register
    squelch_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_rx |=> sq_q == $past(bus.wdata[6:4]))
        else $error("squelch not written");
    // Equalization field follows a write
    eq_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_rx |=> eq_q == $past(bus.wdata[2:0]))
        else $error("equalization not written");
    // Duration field follows a write
    dur_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_tx |=> dur_q == $past(bus.wdata[5:4]))
        else $error("duration not written");
    // Legal level codes are stored, code 111 is dropped
    level_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_tx |=> lvl_q == (($past(bus.wdata[2:0]) == 3'h7) ? $past(lvl_q)
                                                          : $past(bus.wdata[2:0])))
        else $error("level write wrong");
    // eUSB2 de-emphasis follows a write
    edeemph_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_etx |=> ede_q == $past(bus.wdata[1:0]))
        else $error("eUSB2 level not written");
    // Unused bit slots of the two USB2 registers (06 and 07) never read as one
    unused_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (bus.addr == 8'h06 || bus.addr == 8'h07) |->
            bus.rdata[7] == 1'b0 && bus.rdata[3] == 1'b0 &&
            (bus.addr == 8'h06 || bus.rdata[6] == 1'b0))
        else $error("unused bit read as one");
endmodule
`default_nettype wire

// ---- src/usb2_hs_signal_tuning_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module usb2_hs_signal_tuning_regs (
    input  wire logic       REF_CLK_IN,              // Core clock, 250 MHz
    input  wire logic       RESETN_IN,               // Synchronous reset, active low
    input  wire logic       SCL_IN,                  // Serial clock pin level
    input  wire logic       SDA_IN,                  // Serial data pin level
    output logic            SDA_OUT,                 // Serial data drive value, always low
    output logic            SDA_OE_OUT,              // High while pulling serial data low
    input  wire logic       HS_RX_ACTIVE_IN,         // Receiver is in high-speed mode
    output logic [2:0]      USB2_HS_SQUELCH_OUT,     // Squelch threshold code
    output logic [2:0]      USB2_HS_RX_EQ_OUT,       // Equalization code, zero outside HS
    output logic            USB2_HS_RX_TUNE_EN_OUT,  // Receive tuning in force
    output logic [1:0]      USB2_HS_DEEMPH_DUR_OUT,  // De-emphasis duration code
    output logic [2:0]      USB2_HS_DEEMPH_LVL_OUT,  // De-emphasis level code
    output logic [1:0]      EUSB2_HS_DEEMPH_LVL_OUT, // eUSB2 de-emphasis level code
    output logic [1:0]      EUSB2_HS_TX_SWING_OUT    // eUSB2 output swing code
);
    // Serial protocol states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,  // Waiting for a start
        ST_ADDR  = 7'h02,  // Shifting the address byte
        ST_ACKA  = 7'h04,  // Acknowledging the address
        ST_WDATA = 7'h08,  // Shifting a written byte
        ST_ACKW  = 7'h10,  // Acknowledging a written byte
        ST_RDATA = 7'h20,  // Sending a read byte
        ST_ACKR  = 7'h40   // Sampling the controller acknowledge
    } i2c_state_e;

    reg_if bus ();  // Access path to the register bank

    // Pin synchronisers: bit 0 clock, bit 1 data, bit 2 high-speed flag
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;  // Previous synchronised clock and data

    // Protocol state
    i2c_state_e state_q;
    logic [7:0] shift_q;    // Shift register for in and out bytes
    logic [2:0] cnt_q;      // Bit counter
    logic       done_q;     // Eight bits shifted
    logic       first_q;    // Next written byte is the pointer
    logic       rw_q;       // Read requested in the address byte
    logic       mack_q;     // Controller acknowledged the read byte
    logic [7:0] ptr_q;      // Register pointer
    logic       wr_q;       // Write pulse into the bank
    logic       oe_q;       // Data pin pull-down
    logic       sda_out_q;  // Drive value of the data pin

    // Bank fields
    logic [2:0] sq_w;
    logic [2:0] eq_w;
    logic [1:0] dur_w;
    logic [2:0] lvl_w;
    logic [1:0] esw_w;
    logic [1:0] ede_w;

    // Bus events decoded from the synchronised pins
    wire logic scl_s    = sync2_q[0];
    wire logic sda_s    = sync2_q[1];
    wire logic hs_s     = sync2_q[2];
    wire logic scl_rise = scl_s & ~prev_q[0];
    wire logic scl_fall = ~scl_s & prev_q[0];
    wire logic start    = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
    wire logic stop     = scl_s & prev_q[0] & ~prev_q[1] & sda_s;
    wire logic addr_hit = shift_q[7:1] == tuning_pkg::TARGET_ADDR;
    wire logic last_bit = cnt_q == 3'h7;

    assign bus.wr_stb = wr_q;
    assign bus.addr   = ptr_q;
    assign bus.wdata  = shift_q;

    // Register bank
    tuning_regs u_regs (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESETN_IN),
        .bus      (bus),
        .sq_out   (sq_w),
        .eq_out   (eq_w),
        .dur_out  (dur_w),
        .lvl_out  (lvl_w),
        .esw_out  (esw_w),
        .ede_out  (ede_w)
    );

    // Two-stage synchronisers and edge history
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            sync1_q <= 3'h3;
            sync2_q <= 3'h3;
            prev_q  <= 2'h3;
        end else begin
            sync1_q <= {HS_RX_ACTIVE_IN, SDA_IN, SCL_IN};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q[1:0];
        end
    end

    // Serial target: address match, pointer, auto-increment writes and reads
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q   <= 3'h0;
            done_q  <= 1'b0;
            first_q <= 1'b0;
            rw_q    <= 1'b0;
            mack_q  <= 1'b0;
            ptr_q   <= 8'h00;
            wr_q    <= 1'b0;
            oe_q    <= 1'b0;
        end else if (start) begin
            // Start or repeated start: expect an address
            state_q <= ST_ADDR;
            cnt_q   <= 3'h0;
            done_q  <= 1'b0;
            wr_q    <= 1'b0;
            oe_q    <= 1'b0;
        end else if (stop) begin
            // Stop releases the bus
            state_q <= ST_IDLE;
            wr_q    <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (wr_q) begin
                ptr_q <= ptr_q + 8'h01;  // Advance after each stored byte
            end
            case (state_q)
                ST_ADDR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q   <= cnt_q + 3'h1;
                        done_q  <= last_bit;
                    end else if (scl_fall && done_q) begin
                        done_q <= 1'b0;
                        if (state_q == ST_ADDR) begin
                            // Acknowledge only our own address
                            state_q <= addr_hit ? ST_ACKA : ST_IDLE;
                            oe_q    <= addr_hit;
                            rw_q    <= shift_q[0];
                        end else begin
                            state_q <= ST_ACKW;
                            oe_q    <= 1'b1;
                            first_q <= 1'b0;
                            if (first_q) begin
                                ptr_q <= shift_q;  // First byte sets the pointer
                            end else begin
                                wr_q <= 1'b1;
                            end
                        end
                    end
                end
                ST_ACKA, ST_ACKW: begin
                    if (scl_fall) begin
                        cnt_q <= 3'h0;
                        if (rw_q) begin
                            // Present the first read byte
                            state_q <= ST_RDATA;
                            shift_q <= bus.rdata;
                            oe_q    <= ~bus.rdata[7];
                            ptr_q   <= ptr_q + 8'h01;
                        end else begin
                            state_q <= ST_WDATA;
                            oe_q    <= 1'b0;
                            first_q <= state_q == ST_ACKA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_q  <= cnt_q + 3'h1;
                        done_q <= last_bit;
                    end else if (scl_fall) begin
                        if (done_q) begin
                            done_q  <= 1'b0;
                            state_q <= ST_ACKR;
                            oe_q    <= 1'b0;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            oe_q    <= ~shift_q[6];
                        end
                    end
                end
                ST_ACKR: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s;
                    end else if (scl_fall) begin
                        // Acknowledged: next byte; otherwise stay off the bus
                        cnt_q   <= 3'h0;
                        state_q <= mack_q ? ST_RDATA : ST_IDLE;
                        if (mack_q) begin
                            shift_q <= bus.rdata;
                            oe_q    <= ~bus.rdata[7];
                            ptr_q   <= ptr_q + 8'h01;
                        end
                    end
                end
                ST_IDLE: begin
                    oe_q <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    oe_q    <= 1'b0;
                end
            endcase
        end
    end

    // Output flops toward the analog front ends
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            sda_out_q              <= 1'b0;
            USB2_HS_SQUELCH_OUT    <= tuning_pkg::SQ_RST;
            USB2_HS_RX_EQ_OUT      <= 3'h0;
            USB2_HS_RX_TUNE_EN_OUT <= 1'b0;
            USB2_HS_DEEMPH_DUR_OUT <= tuning_pkg::DUR_RST;
            USB2_HS_DEEMPH_LVL_OUT <= tuning_pkg::LVL_RST;
            EUSB2_HS_DEEMPH_LVL_OUT <= tuning_pkg::EDE_RST;
            EUSB2_HS_TX_SWING_OUT  <= tuning_pkg::ESW_RST;
        end else begin
            sda_out_q              <= 1'b0;
            USB2_HS_SQUELCH_OUT    <= sq_w;
            USB2_HS_RX_EQ_OUT      <= hs_s ? eq_w : 3'h0;
            USB2_HS_RX_TUNE_EN_OUT <= hs_s;
            USB2_HS_DEEMPH_DUR_OUT <= dur_w;
            USB2_HS_DEEMPH_LVL_OUT <= lvl_w;
            EUSB2_HS_DEEMPH_LVL_OUT <= ede_w;
            EUSB2_HS_TX_SWING_OUT  <= esw_w;
        end
    end

    assign SDA_OUT    = sda_out_q;
    assign SDA_OE_OUT = oe_q;

    // Start condition followed by address shifting
    sequence start_s;
        start ##1 (state_q == ST_ADDR);
    endsequence
    sequence wbyte_s;
        (state_q == ST_WDATA) && scl_fall && done_q && !first_q && !start && !stop;
    endsequence

    // Equalization is held at zero outside high-speed reception
    hs_only_eq_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
        !hs_s |=> USB2_HS_RX_EQ_OUT == 3'h0 && !USB2_HS_RX_TUNE_EN_OUT)
        else $error("eq applied outside HS");
    // A start always leads to address shifting with the pin released
    start_addr_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
        start_s |-> !SDA_OE_OUT)
        else $error("start not honoured");
    // A completed data byte is acknowledged and written one cycle later
    write_ack_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
        wbyte_s |=> SDA_OE_OUT && wr_q ##1 !wr_q)
        else $error("write byte lost");
    // Data pin is pulled only in acknowledge or read phases
    drive_window_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
        SDA_OE_OUT |-> state_q inside {ST_ACKA, ST_ACKW, ST_RDATA})
        else $error("pin driven out of phase");
endmodule
`default_nettype wire

// ---- tb/usb2_hs_signal_tuning_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// Drives the serial target port and checks the tuning outputs
module usb2_hs_signal_tuning_regs_tb;
    localparam int Q = 64;              // Clocks per quarter of a serial bit, keeps SCL <= 1 MHz
    logic        clk;                   // Core clock
    logic        rst_n;                 // Reset, active low
    logic        scl;                   // Serial clock from the bench
    logic        sda_drv;               // Bench data drive, 1 = released
    logic        hs_active;             // Receiver high-speed flag
    logic        sda_o;                 // Target data drive value
    logic        sda_oe;                // Target pulls data low
    logic [2:0]  sq;                    // Squelch code
    logic [2:0]  eq;                    // Equalization code
    logic        ten;                   // Receive tuning enable
    logic [1:0]  dur;                   // De-emphasis duration
    logic [2:0]  lvl;                   // De-emphasis level
    logic [1:0]  ede;                   // eUSB2 de-emphasis
    logic [1:0]  esw;                   // eUSB2 swing
    wire         sda_wire;              // Resolved open-drain data line
    logic [7:0]  exp_q[$];              // Expected bytes and acknowledges
    logic [7:0]  res_val;               // Latest observed result
    event        res_ev;                // Fires when a result is ready
    int          n_fail;                // Mismatch counter
    int          total_checks;          // Comparison counter
    integer      seed;                  // Random seed
    logic [2:0]  sq_e;                  // Expected squelch
    logic [2:0]  eq_e;                  // Expected equalization
    logic [1:0]  dur_e;                 // Expected duration
    logic [2:0]  lvl_e;                 // Expected level
    logic [1:0]  ede_e;                 // Expected eUSB2 de-emphasis
    logic [1:0]  esw_e;                 // Expected eUSB2 swing
    logic [7:0]  w_addr;                // Address byte for writes
    logic [7:0]  r_addr;                // Address byte for reads

    // Pull-up wins unless some party pulls low
    assign sda_wire = sda_drv & (sda_oe ? sda_o : 1'b1);
    assign w_addr = {tuning_pkg::TARGET_ADDR, 1'b0};
    assign r_addr = {tuning_pkg::TARGET_ADDR, 1'b1};

    usb2_hs_signal_tuning_regs dut_u (
        .REF_CLK_IN              (clk),
        .RESETN_IN               (rst_n),
        .SCL_IN                  (scl),
        .SDA_IN                  (sda_wire),
        .SDA_OUT                 (sda_o),
        .SDA_OE_OUT              (sda_oe),
        .HS_RX_ACTIVE_IN         (hs_active),
        .USB2_HS_SQUELCH_OUT     (sq),
        .USB2_HS_RX_EQ_OUT       (eq),
        .USB2_HS_RX_TUNE_EN_OUT  (ten),
        .USB2_HS_DEEMPH_DUR_OUT  (dur),
        .USB2_HS_DEEMPH_LVL_OUT  (lvl),
        .EUSB2_HS_DEEMPH_LVL_OUT (ede),
        .EUSB2_HS_TX_SWING_OUT   (esw)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compares one byte or acknowledge
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares the packed field outputs
    task automatic cmp_field(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t fields got %h expected %h", $time, got, exp);
        end
    endtask

    // Eq is only passed on while high-speed reception is flagged
    task automatic chk_fields();
        cmp_field({sq, eq, ten, dur, lvl, ede, esw},
                  {sq_e, hs_active ? eq_e : 3'h0, hs_active, dur_e, lvl_e, ede_e, esw_e});
    endtask

    // Monitor takes the oldest note for every observed result
    always begin
        @(res_ev);
        cmp_byte(res_val, exp_q.pop_front());
    end

    // One quarter of a serial bit
    task automatic tick();
        repeat (Q) @(posedge clk);
    endtask

    // Start or repeated start, ends with clock low
    task automatic start();
        sda_drv <= 1'b1; tick();
        scl <= 1'b1; tick();
        sda_drv <= 1'b0; tick();
        scl <= 1'b0; tick();
    endtask

    // Stop condition, bus left idle
    task automatic stop();
        sda_drv <= 1'b0; tick();
        scl <= 1'b1; tick();
        sda_drv <= 1'b1; tick();
    endtask

    // Data changes only while the clock is low
    task automatic bit_out(input logic b);
        sda_drv <= b; tick();
        scl <= 1'b1; tick();
        tick();
        scl <= 1'b0; tick();
    endtask

    // Releases data and samples the wire mid-high
    task automatic bit_in(output logic b);
        sda_drv <= 1'b1; tick();
        scl <= 1'b1; tick();
        b = sda_wire;
        tick();
        scl <= 1'b0; tick();
    endtask

    // Sends a byte, MSB first, and reports the acknowledge
    task automatic send(input logic [7:0] b, input logic [7:0] ack_exp);
        logic a;
        exp_q.push_back(ack_exp);
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_in(a);
        res_val = {7'h0, ~a};
        -> res_ev;
    endtask

    // Receives a byte, then acknowledges or ends with a refusal
    task automatic recv(input logic last);
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) bit_in(v[i]);
        bit_out(last);
        res_val = v;
        -> res_ev;
    endtask

    // Pointer then one or two data bytes
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
        start();
        send(w_addr, 8'h01);
        send(ptr, 8'h01);
        send(d0, 8'h01);
        if (n > 1) send(d1, 8'h01);
        stop();
    endtask

    // Pointer write, repeated start, burst read of n bytes
    task automatic rd(input logic [7:0] ptr, input logic [7:0] e [3], input int n);
        start();
        send(w_addr, 8'h01);
        send(ptr, 8'h01);
        start();
        send(r_addr, 8'h01);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(e[i]);
            recv(i == n - 1);
        end
        stop();
    endtask

    // Prints counts and the verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cuts a hung run short
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        conclude();
    end

    // Main sequence
    initial begin
        logic [7:0] r6;
        logic [7:0] r7;
        rst_n = 1'b0;
        scl = 1'b1;
        sda_drv = 1'b1;
        hs_active = 1'b0;
        n_fail = 0;
        total_checks = 0;
        seed = 32'he9bc8a87;
        sq_e = 3'h4;
        eq_e = 3'h0;
        dur_e = 2'h2;
        lvl_e = 3'h2;
        ede_e = 2'h0;
        esw_e = 2'h1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_fields();
        // Reset values with unused slots reading zero
        rd(8'h05, '{8'h10, 8'h40, 8'h22}, 3);
        hs_active <= 1'b1;
        repeat (8) @(posedge clk);
        chk_fields();
        // Random legal codes with unused slots set in the written bytes
        for (int k = 0; k < 2; k++) begin
            sq_e = 3'(($unsigned($random(seed)) % 7) + 1);
            eq_e = 3'($unsigned($random(seed)) % 5);
            dur_e = 2'($unsigned($random(seed)) % 3);
            lvl_e = 3'($unsigned($random(seed)) % 7);
            r6 = {1'b1, sq_e, 1'b1, eq_e};
            r7 = {2'b11, dur_e, 1'b1, lvl_e};
            wr(8'h06, r6, r7, 2);
            chk_fields();
            rd(8'h06, '{{1'b0, sq_e, 1'b0, eq_e}, {2'b00, dur_e, 1'b0, lvl_e}, 8'h00}, 2);
        end
        // Reserved level code keeps the old level, duration still taken
        dur_e = 2'h1;
        wr(8'h07, {2'b00, 2'b01, 1'b0, 3'b111}, 8'h00, 1);
        chk_fields();
        // eUSB2 transmit register takes random codes, unused slots set
        ede_e = 2'($random(seed));
        esw_e = 2'($random(seed));
        wr(8'h05, {2'b11, esw_e, 2'b11, ede_e}, 8'h00, 1);
        chk_fields();
        // Outside high-speed the equalization is withheld
        hs_active <= 1'b0;
        repeat (8) @(posedge clk);
        chk_fields();
        // Another address gets no acknowledge
        start();
        send({tuning_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, 8'h00);
        stop();
        repeat (8) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
